// ===== sfpi_pkg.sv
/*
 serial flash pin interface: shared constants, lane modes and lane decoding.
 assumes one 10 MHz system clock on both ends of the link.
*/
`default_nettype none
package sfpi_pkg;
	typedef enum logic [1:0] {SFPI_SINGLE, SFPI_DUAL, SFPI_QUAD} sfpi_mode_t;
	localparam int MCLK_NS = 100;
	// restart pin low time and its cycle count, rounded up
	localparam int T_RESTART_NS = 1000;
	localparam int RESTART_CYC = (T_RESTART_NS + MCLK_NS - 1) / MCLK_NS;
	// host serial clock half period; long enough for two-stage sync on both ends
	localparam int SCLK_HALF_CYC = 8;
	// host command registers
	localparam logic [3:0] HREG_CTRL = 4'h0;
	localparam logic [3:0] HREG_TX = 4'h4;
	localparam logic [3:0] HREG_RX = 4'h8;
	localparam logic [3:0] HREG_STAT = 4'hc;
	localparam int CTRL_CS = 0;
	localparam int CTRL_MODE = 1;
	localparam int CTRL_READ = 3;
	localparam int CTRL_CPOL = 4;
	localparam int CTRL_PROT_N = 5;
	localparam int CTRL_PAUSE_N = 6;
	localparam int CTRL_RESTART_N = 7;
	localparam logic [7:0] CTRL_RST = 8'he0;

	// bits moved per serial clock in each mode
	function automatic logic [3:0] sfpi_width(input sfpi_mode_t m);
		case (m)
			SFPI_DUAL: return 4'h2;
			SFPI_QUAD: return 4'h4;
			default: return 4'h1;
		endcase
	endfunction

	// lanes that carry data in each mode (single mode reads out on lane1)
	function automatic logic [3:0] sfpi_mask(input sfpi_mode_t m, input logic rd);
		case (m)
			SFPI_DUAL: return 4'h3;
			SFPI_QUAD: return 4'hf;
			default: return rd ? 4'h2 : 4'h1;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== sfpi_if.sv
/*
 serial flash pin interface: the pin bundle between host and flash device.
 assumes each end drives lanes only through its own output enables; undriven lanes pull high.
*/
`default_nettype none
interface sfpi_if;
	logic sclk;
	logic cs_n;
	logic restart_n;
	logic [3:0] h_lane_o;
	logic [3:0] h_lane_oe;
	logic [3:0] d_lane_o;
	logic [3:0] d_lane_oe;
	logic [3:0] lane;

	// wire level: device wins, then host, else pull-up
	assign lane = (d_lane_oe & d_lane_o) | (~d_lane_oe & h_lane_oe & h_lane_o) |
		(~d_lane_oe & ~h_lane_oe);

	modport dev (input sclk, cs_n, restart_n, lane, output d_lane_o, d_lane_oe);
	modport host (output sclk, cs_n, restart_n, h_lane_o, h_lane_oe, input lane);
endinterface
`default_nettype wire

// ===== sfpi_sync.sv
/*
 serial flash pin interface: two-flop synchroniser for pins from outside the clock domain.
 assumes i_ce freezes it along with the rest of the block.
*/
`default_nettype none
module sfpi_sync #(
	parameter int W = 1
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			meta_ff <= '0;
			o_q <= '0;
		end
		else if (i_ce)
		begin
			meta_ff <= i_d;
			o_q <= meta_ff;
		end
	end
endmodule // sfpi_sync
`default_nettype wire

// ===== sfpi_device.sv
/*
 serial flash pin interface: flash device end. samples the host's pins, shifts
 bytes in and out per lane mode, handles pause, protect and restart pins.
 assumes an instruction decoder on the user side picks mode and output phase.
*/
// The implementer's own choices: the register offsets and the plain strobed port.
`default_nettype none
// Overview of operation
// - deselected: all data lanes float
// - select low: accept input, allow readout
// - ignore input until first select fall
// - single mode samples serial_in on rise
// - single mode drives serial_out on fall
// - dual/quad: in on rise, out on fall
// - quad only when quad_lane_enable set
// - quad enable turns pins into lane2/lane3
// - single/dual use lane0-1, quad uses four
// - pin functions only outside quad operation
// - protect_n low rejects status writes when i_status_lock_select set
// - protect pin locks protected region settings when i_status_lock_select set
// - pause floats output, ignores clock/input
// - pause release resumes from held state
// - shared pin is pause or restart
// - quad enable removes pause and shared restart
// - dedicated restart pin ignores quad enable
// - host may reset device via restart
// - function select zero pause, one restart (pause when dedicated restart)
// - pause takes effect only with clock low
// - restart low 1us aborts to power-on
// - clock modes 0 and 3 supported
module sfpi_device (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	sfpi_if.dev bus,
	input wire sfpi_pkg::sfpi_mode_t i_mode,
	input wire logic i_out_phase,
	input wire logic [7:0] i_tx_byte,
	input wire logic i_quad_lane_enable,
	input wire logic i_pin3_function_select,
	input wire logic i_status_lock_select,
	input wire logic i_has_dedicated_restart,
	input wire logic i_sr_write_req,
	output logic o_selected,
	output logic o_paused,
	output logic o_restart,
	output logic [7:0] o_rx_byte,
	output logic o_rx_valid,
	output logic o_tx_taken,
	output logic o_quad_refused,
	output logic o_hw_locked,
	output logic o_sr_write_grant,
	output logic o_sr_write_reject
);
	import sfpi_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic [6:0] pins_s;
	logic s_sclk;
	logic s_cs_n;
	logic [3:0] s_lane;
	logic s_rst_ded;
	logic sclk_q_ff;
	logic cs_q_ff;
	logic armed_ff;
	logic [3:0] rst_cnt_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] rx_sh_ff;
	logic [7:0] tx_sh_ff;
	logic [3:0] out_ff;
	logic [3:0] oe_ff;

	sfpi_sync #(.W(7)) u_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_d({bus.restart_n, bus.lane, bus.cs_n, bus.sclk}),
		.o_q(pins_s)
	);
	assign s_sclk = pins_s[0];
	assign s_cs_n = pins_s[1];
	assign s_lane = pins_s[5:2];
	assign s_rst_ded = pins_s[6];

	////////////////////////////////////////////////////////////////////////////
	// edges; works for idle-low and idle-high clock alike
	wire sclk_rise = s_sclk & ~sclk_q_ff;
	wire sclk_fall = ~s_sclk & sclk_q_ff;
	wire cs_fall = ~s_cs_n & cs_q_ff;
	wire qe = i_quad_lane_enable;
	// pin roles of lane2/lane3
	wire pause_en = ~qe & (~i_pin3_function_select | i_has_dedicated_restart);
	wire shared_rst_en = ~qe & i_pin3_function_select & ~i_has_dedicated_restart;
	wire protect_n_pin = qe | s_lane[2];
	wire restart_low = (i_has_dedicated_restart & ~s_rst_ded) |
		(shared_rst_en & ~s_lane[3]);
	wire restart_hit = restart_low & (rst_cnt_ff == 4'(RESTART_CYC - 1));
	wire sel = ~s_cs_n & armed_ff;
	wire pause_req = sel & pause_en & ~s_lane[3];
	// pause toggles only while the serial clock sits low
	wire pause_move = (pause_req != o_paused) & ~s_sclk;
	wire mode_ok = (i_mode != SFPI_QUAD) | qe;
	wire active = sel & ~o_paused & ~restart_low & mode_ok;
	wire [3:0] w = sfpi_width(i_mode);
	wire [3:0] cnt_sum = {1'b0, bit_cnt_ff} + w;
	wire do_in = active & sclk_rise & ~i_out_phase;
	wire do_out = active & sclk_fall & i_out_phase;
	// idle-low clock gives no fall before the first rise, so the first bits go out at phase start
	wire out_start = active & i_out_phase & ~s_sclk & (oe_ff == 4'h0) & (bit_cnt_ff == 3'h0);
	wire load_out = do_out | out_start;
	// lane0 is least significant in every mode
	wire [7:0] nxt_rx = (i_mode == SFPI_QUAD) ? {rx_sh_ff[3:0], s_lane} :
		(i_mode == SFPI_DUAL) ? {rx_sh_ff[5:0], s_lane[1:0]} :
		{rx_sh_ff[6:0], s_lane[0]};
	wire [7:0] tx_src = (bit_cnt_ff == 3'h0) ? i_tx_byte : tx_sh_ff;
	wire [3:0] nxt_out = (i_mode == SFPI_QUAD) ? tx_src[7:4] :
		(i_mode == SFPI_DUAL) ? {2'h0, tx_src[7:6]} : {2'h0, tx_src[7], 1'b0};
	wire [3:0] nxt_oe = (active & i_out_phase) ? sfpi_mask(i_mode, 1'b1) : 4'h0;
	wire sr_lock = ~protect_n_pin & i_status_lock_select;

	assign bus.d_lane_o = out_ff;
	assign bus.d_lane_oe = oe_ff;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			sclk_q_ff <= 1'b0;
			cs_q_ff <= 1'b0;
			rst_cnt_ff <= 4'h0;
			o_restart <= 1'b0;
		end
		else if (i_ce)
		begin
			sclk_q_ff <= s_sclk;
			cs_q_ff <= s_cs_n;
			o_restart <= restart_hit;
			if (!restart_low)
				rst_cnt_ff <= 4'h0;
			else if (rst_cnt_ff != 4'(RESTART_CYC))
				rst_cnt_ff <= rst_cnt_ff + 4'h1;
		end
	end

	// select, arm and pause; restart returns to the power-on state
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n || (i_ce && restart_hit))
		begin
			armed_ff <= 1'b0;
			o_paused <= 1'b0;
			o_selected <= 1'b0;
		end
		else if (i_ce)
		begin
			if (cs_fall && !restart_low)
				armed_ff <= 1'b1;
			o_selected <= sel;
			if (!sel)
				o_paused <= 1'b0;
			else if (pause_move)
				o_paused <= pause_req;
		end
	end

	// shift state is simply held while paused, so release resumes in place
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n || (i_ce && (restart_hit || s_cs_n)))
		begin
			bit_cnt_ff <= 3'h0;
			rx_sh_ff <= 8'h00;
			tx_sh_ff <= 8'h00;
			out_ff <= 4'h0;
			oe_ff <= 4'h0;
			o_rx_valid <= 1'b0;
			o_tx_taken <= 1'b0;
		end
		else if (i_ce)
		begin
			oe_ff <= nxt_oe;
			o_rx_valid <= do_in & cnt_sum[3];
			o_tx_taken <= load_out & (bit_cnt_ff == 3'h0);
			if (do_in)
				rx_sh_ff <= nxt_rx;
			if (load_out)
			begin
				out_ff <= nxt_out;
				tx_sh_ff <= tx_src << w;
			end
			if (do_in || load_out)
				bit_cnt_ff <= cnt_sum[2:0];
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_rx_byte <= 8'h00;
			o_quad_refused <= 1'b0;
			o_hw_locked <= 1'b0;
			o_sr_write_grant <= 1'b0;
			o_sr_write_reject <= 1'b0;
		end
		else if (i_ce)
		begin
			if (do_in && cnt_sum[3])
				o_rx_byte <= nxt_rx;
			o_quad_refused <= sel & ~mode_ok;
			// region fields cannot change while locked
			o_hw_locked <= sr_lock;
			o_sr_write_grant <= i_sr_write_req & ~sr_lock;
			o_sr_write_reject <= i_sr_write_req & sr_lock;
		end
	end
endmodule // sfpi_device
`default_nettype wire

// ===== sfpi_host.sv
/*
 serial flash pin interface: host controller end. software drives it through a
 small register port; it makes the serial clock by dividing its own clock.
 assumes software keeps chip select and pin levels legal between transfers.
*/
`default_nettype none
module sfpi_host (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	sfpi_if.host bus,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_we,
	input wire logic i_re,
	output logic [7:0] o_rdata
);
	import sfpi_pkg::*;

	typedef enum {SFPIH_IDLE, SFPIH_LOW, SFPIH_HIGH} sfpih_state_t;

	////////////////////////////////////////////////////////////////////////////
	sfpih_state_t state_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] tx_sh_ff;
	logic [7:0] rx_sh_ff;
	logic [7:0] rx_ff;
	logic [3:0] half_ff;
	logic [3:0] left_ff;
	logic sclk_ff;
	logic [3:0] lane_o_ff;
	logic [3:0] lane_oe_ff;
	logic [3:0] s_lane;

	sfpi_sync #(.W(4)) u_sync (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_d(bus.lane),
		.o_q(s_lane)
	);

	wire sfpi_mode_t mode = sfpi_mode_t'(ctrl_ff[CTRL_MODE +: 2]);
	wire rd = ctrl_ff[CTRL_READ];
	wire [3:0] w = sfpi_width(mode);
	wire busy = (state_ff != SFPIH_IDLE);
	wire start = i_we & (i_addr == HREG_TX) & ~busy;
	wire half_end = (half_ff == 4'(SCLK_HALF_CYC - 1));
	wire [7:0] nxt_rx = (mode == SFPI_QUAD) ? {rx_sh_ff[3:0], s_lane} :
		(mode == SFPI_DUAL) ? {rx_sh_ff[5:0], s_lane[1:0]} : {rx_sh_ff[6:0], s_lane[1]};
	wire [3:0] data_o = (mode == SFPI_QUAD) ? tx_sh_ff[7:4] :
		(mode == SFPI_DUAL) ? {2'h0, tx_sh_ff[7:6]} : {3'h0, tx_sh_ff[7]};
	// single mode always drives serial_in; wider modes let go of lanes to read
	wire [3:0] data_oe = (mode == SFPI_SINGLE) ? 4'h1 : (rd ? 4'h0 : sfpi_mask(mode, 1'b0));
	// outside quad, lane2 carries protect_n and lane3 pause or restart
	wire [3:0] side_o = {ctrl_ff[CTRL_PAUSE_N] & ctrl_ff[CTRL_RESTART_N], ctrl_ff[CTRL_PROT_N], 2'h0};
	wire [3:0] side_oe = (mode == SFPI_QUAD) ? 4'h0 : 4'hc;
	wire [3:0] nxt_oe = ctrl_ff[CTRL_CS] ? (data_oe | side_oe) : side_oe;
	wire [3:0] nxt_o = (data_o & data_oe) | (side_o & side_oe);

	assign bus.sclk = sclk_ff;
	assign bus.h_lane_o = lane_o_ff;
	assign bus.h_lane_oe = lane_oe_ff;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			ctrl_ff <= CTRL_RST;
			bus.cs_n <= 1'b1;
			bus.restart_n <= 1'b1;
			lane_o_ff <= 4'h0;
			lane_oe_ff <= 4'h0;
			o_rdata <= 8'h00;
		end
		else if (i_ce)
		begin
			if (i_we && i_addr == HREG_CTRL)
				ctrl_ff <= i_wdata;
			bus.cs_n <= ~ctrl_ff[CTRL_CS];
			bus.restart_n <= ctrl_ff[CTRL_RESTART_N];
			lane_o_ff <= nxt_o;
			lane_oe_ff <= nxt_oe;
			o_rdata <= 8'h00;
			if (i_re)
			begin
				case (i_addr)
					HREG_CTRL: o_rdata <= ctrl_ff;
					HREG_RX: o_rdata <= rx_ff;
					HREG_STAT: o_rdata <= {7'h00, busy};
					default: o_rdata <= 8'h00;
				endcase
			end
		end
	end

	// data changes right after each falling edge and is sampled at each rise
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			state_ff <= SFPIH_IDLE;
			sclk_ff <= 1'b0;
			half_ff <= 4'h0;
			left_ff <= 4'h0;
			tx_sh_ff <= 8'h00;
			rx_sh_ff <= 8'h00;
			rx_ff <= 8'h00;
		end
		else if (i_ce)
		begin
			half_ff <= half_end ? 4'h0 : half_ff + 4'h1;
			case (state_ff)
				SFPIH_IDLE:
				begin
					sclk_ff <= ctrl_ff[CTRL_CPOL];
					half_ff <= 4'h0;
					if (start)
					begin
						sclk_ff <= 1'b0;
						tx_sh_ff <= i_wdata;
						left_ff <= 4'(8 / w);
						state_ff <= SFPIH_LOW;
					end
				end
				SFPIH_LOW:
				if (half_end)
				begin
					sclk_ff <= 1'b1;
					rx_sh_ff <= nxt_rx;
					left_ff <= left_ff - 4'h1;
					state_ff <= SFPIH_HIGH;
				end
				SFPIH_HIGH:
				if (half_end)
				begin
					sclk_ff <= (left_ff == 4'h0) ? ctrl_ff[CTRL_CPOL] : 1'b0;
					tx_sh_ff <= tx_sh_ff << w;
					if (left_ff == 4'h0)
					begin
						rx_ff <= rx_sh_ff;
						state_ff <= SFPIH_IDLE;
					end
					else
						state_ff <= SFPIH_LOW;
				end
				default: state_ff <= SFPIH_IDLE;
			endcase
		end
	end
endmodule // sfpi_host
`default_nettype wire

// ===== sfpi_checker.sv
/*
 sfpi_checker: concurrent checks on the pin bundle joining host and device.
 assumes both ends share i_mclk and a synchronous active-low i_rst_n.
*/
`default_nettype none
module sfpi_checker (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic restart_n,
	input wire logic [3:0] h_lane_o,
	input wire logic [3:0] h_lane_oe,
	input wire logic [3:0] d_lane_o,
	input wire logic [3:0] d_lane_oe,
	input wire logic [3:0] lane
);
	logic cs_n_ff;
	logic armed_ff;
	logic nxt_armed;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////
	// armed here no later than the device, whose synchroniser lags the pin
	assign nxt_armed = armed_ff | (cs_n_ff & ~cs_n);
	always_ff @(posedge i_mclk)
	begin
		cs_n_ff <= i_rst_n ? cs_n : 1'b1;
		armed_ff <= i_rst_n & nxt_armed;
	end
	////////////////////////////////////////
	sequence s_high_half;
		sclk [*8];
	endsequence
	sequence s_low_half;
		!sclk [*8];
	endsequence
	chk_desel_float: assert property (cs_n [*4] |-> d_lane_oe == 4'h0)
		else $error("device drives lanes while deselected");
	chk_unarmed_quiet: assert property (!armed_ff |-> d_lane_oe == 4'h0)
		else $error("device drives lanes before first select");
	chk_dev_fall_edge: assert property ($changed(d_lane_o & d_lane_oe) && $stable(d_lane_oe)
		|-> !sclk)
		else $error("device output changed while clock high");
	chk_no_contention: assert property ((d_lane_oe & h_lane_oe) == 4'h0)
		else $error("both ends drive one lane");
	chk_cs_clk_idle: assert property ($changed(cs_n) |-> $stable(sclk))
		else $error("clock moved at a select edge");
	chk_clk_high_len: assert property ($rose(sclk) |-> s_high_half)
		else $error("clock high phase too short");
	chk_clk_low_len: assert property ($fell(sclk) |-> s_low_half)
		else $error("clock low phase too short");
	chk_host_hold: assert property ($rose(sclk) |=> ($stable(h_lane_o & h_lane_oe)) [*4])
		else $error("host lane changed after rising clock");
endmodule // sfpi_checker
`default_nettype wire

// ===== tb_top.sv
/*
 tb_top: host and device ends joined by the pin bundle, driven through host registers.
 assumes the constants of sfpi_pkg and a 10 MHz system clock.
*/
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sfpi_pkg::*;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [7:0] rdata;
	sfpi_mode_t mode = SFPI_SINGLE;
	logic outph = 1'b0;
	logic [7:0] txb = 8'h00;
	logic qe = 1'b0;
	logic fsel = 1'b0;
	logic lock = 1'b0;
	logic ded = 1'b0;
	logic srq = 1'b0;
	logic paused, rs, rxv, qref, gr, rj, seld, hwl;
	logic [7:0] rxb;
	int n_rx = 0;
	int n_rs = 0;
	int n_gr = 0;
	int n_rj = 0;
	int err_total = 0;
	int n_tests = 0;
	// {quad enable, control, data}
	logic [16:0] ops [9] = '{17'h0e1a5, 17'h0f15a, 17'h0e93c, 17'h0e3c6, 17'h0eb6c,
		17'h1e5e7, 17'h1ed7e, 17'h0e581, 17'h0f999};
	logic [3:0] rs_tab [4] = '{4'h9, 4'h0, 4'hc, 4'h7};
	logic [3:0] sr_tab [4] = '{4'h5, 4'hc, 4'h0, 4'h6};
	////////////////////////////////////////
	sfpi_if i_sfpi_if ();
	sfpi_host i_sfpi_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1),
		.bus(i_sfpi_if.host), .i_addr(addr), .i_wdata(wdata), .i_we(we), .i_re(re),
		.o_rdata(rdata));
	sfpi_device i_sfpi_device (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1),
		.bus(i_sfpi_if.dev), .i_mode(mode), .i_out_phase(outph), .i_tx_byte(txb),
		.i_quad_lane_enable(qe), .i_pin3_function_select(fsel), .i_status_lock_select(lock),
		.i_has_dedicated_restart(ded), .i_sr_write_req(srq), .o_selected(seld),
		.o_paused(paused), .o_restart(rs), .o_rx_byte(rxb), .o_rx_valid(rxv),
		.o_tx_taken(), .o_quad_refused(qref), .o_hw_locked(hwl), .o_sr_write_grant(gr),
		.o_sr_write_reject(rj));
	sfpi_checker i_sfpi_checker (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.sclk(i_sfpi_if.sclk), .cs_n(i_sfpi_if.cs_n), .restart_n(i_sfpi_if.restart_n),
		.h_lane_o(i_sfpi_if.h_lane_o), .h_lane_oe(i_sfpi_if.h_lane_oe),
		.d_lane_o(i_sfpi_if.d_lane_o), .d_lane_oe(i_sfpi_if.d_lane_oe),
		.lane(i_sfpi_if.lane));
	////////////////////////////////////////
	initial
	begin
		forever #50 i_mclk = ~i_mclk;
	end
	// pulses are counted so that no check hangs on the exact cycle
	always @(posedge i_mclk)
	begin
		n_rx <= n_rx + int'(rxv === 1'b1);
		n_rs <= n_rs + int'(rs === 1'b1);
		n_gr <= n_gr + int'(gr === 1'b1);
		n_rj <= n_rj + int'(rj === 1'b1);
	end
	////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge i_mclk);
		we <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		addr <= a;
		re <= 1'b1;
		@(posedge i_mclk);
		re <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic xfer(input logic [7:0] d);
		logic [7:0] s;
		s = 8'h01;
		wr(HREG_TX, d);
		for (int k = 0; k < 200 && s[0] !== 1'b0; k++) rd(HREG_STAT, s);
	endtask
	// deselect first: cpol must not move together with select
	task automatic op(input logic [16:0] t);
		logic [7:0] v;
		logic r;
		int n0;
		r = (t[10:9] == 2'h2) && !t[16];
		n0 = n_rx;
		mode <= sfpi_mode_t'(t[10:9]);
		outph <= t[11];
		txb <= t[7:0];
		qe <= t[16];
		wr(HREG_CTRL, t[15:8] & 8'hfe);
		tick(10);
		wr(HREG_CTRL, t[15:8]);
		tick(10);
		xfer(t[7:0]);
		if (t[11])
		begin
			xfer(8'h00);
			rd(HREG_RX, v);
			chk(v, t[7:0]);
		end
		else
		begin
			tick(6);
			chk(8'(n_rx - n0), {7'h0, !r});
			chk({7'h0, qref}, {7'h0, r});
			if (!r)
				chk(rxb, t[7:0]);
		end
		wr(HREG_CTRL, t[15:8] & 8'hfe);
		tick(6);
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	////////////////////////////////////////
	initial
	begin
		tick(30000);
		err_total++;
		report_and_stop();
	end
	initial
	begin
		logic [7:0] v;
		int n0;
		int n1;
		tick(6);
		i_rst_n <= 1'b1;
		rd(HREG_CTRL, v);
		chk(v, CTRL_RST);
		wr(4'h2, 8'hff);
		rd(4'h2, v);
		chk(v, 8'h00);
		xfer(8'h81);
		tick(6);
		chk(8'(n_rx), 8'h00);
		foreach (ops[i]) op(ops[i]);
		outph <= 1'b1;
		txb <= 8'h96;
		wr(HREG_CTRL, 8'ha8);
		tick(10);
		wr(HREG_CTRL, 8'ha9);
		tick(10);
		n0 = n_rx;
		chk({7'h0, paused}, 8'h01);
		chk({7'h0, seld}, 8'h01);
		xfer(8'h33);
		chk({4'h0, i_sfpi_if.d_lane_oe}, 8'h00);
		chk(8'(n_rx - n0), 8'h00);
		wr(HREG_CTRL, 8'he9);
		tick(10);
		chk({7'h0, paused}, 8'h00);
		xfer(8'h00);
		xfer(8'h00);
		rd(HREG_RX, v);
		chk(v, 8'h96);
		wr(HREG_CTRL, 8'he8);
		tick(6);
		outph <= 1'b0;
		foreach (rs_tab[i])
		begin
			fsel <= rs_tab[i][3];
			qe <= rs_tab[i][2];
			ded <= rs_tab[i][1];
			n0 = n_rs;
			wr(HREG_CTRL, 8'h61);
			tick(20);
			wr(HREG_CTRL, 8'he1);
			tick(10);
			chk(8'(n_rs - n0), {7'h0, rs_tab[i][0]});
			n0 = n_rx;
			xfer(8'h42);
			tick(6);
			chk(8'(n_rx - n0), {7'h0, !rs_tab[i][0]});
			wr(HREG_CTRL, 8'he0);
			tick(6);
		end
		foreach (sr_tab[i])
		begin
			lock <= sr_tab[i][2];
			qe <= sr_tab[i][1];
			n0 = n_rj;
			n1 = n_gr;
			wr(HREG_CTRL, {2'h3, sr_tab[i][3], 5'h00});
			tick(6);
			srq <= 1'b1;
			tick(1);
			srq <= 1'b0;
			tick(3);
			chk(8'(n_rj - n0), {7'h0, sr_tab[i][0]});
			chk(8'(n_gr - n1), {7'h0, !sr_tab[i][0]});
			chk({7'h0, hwl}, {7'h0, sr_tab[i][0]});
		end
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
